//--- rtl/ocl_pkg.sv
// Package for the stored-configuration lock and discharge controller.
package ocl_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses on the Avalon-MM slave)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CFG0 = 4'h0;
    localparam logic [3:0] OFS_CFG1 = 4'h4;
    localparam logic [3:0] OFS_CFG2 = 4'h8;
    localparam logic [3:0] OFS_CMD = 4'hc;
    localparam int ADDR_W = 4;
    // ----------------------------------------------------------------
    // Command and configuration register fields
    // ----------------------------------------------------------------
    localparam int CMD_WSM = 7;
    localparam int CMD_CF = 6;
    localparam int CMD_RST = 5;
    localparam int CMD_POWER_SWITCHES_OFF = 4;
    localparam int CFG2_LOCK = 6;
    localparam int CFG2_DIS = 2;
    localparam logic [1:0] SEQ_TOGETHER = 2'b11;
    localparam logic [7:0] CMD_RESET_VAL = 8'h00;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    localparam logic [7:0] CMD_WMASK = 8'hf7;
    // Stored-byte width mask: 23 programmable bits, bit 7 of byte 2 unused.
    localparam logic [7:0] CFG2_MASK = 8'h7f;
    // ----------------------------------------------------------------
    // Power-down sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PD_RUN,
        PD_OFF,
        PD_DISCHARGE,
        PD_DOWN
    } ocl_pd_e;
endpackage : ocl_pkg

//--- rtl/ocl_ctrl.sv
// Stored-configuration select, program, lock and power-down discharge control.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module ocl_ctrl (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ocl_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic enable_input_n,
    input wire logic pos_discharged,
    input wire logic neg_discharged,
    output logic converters_on,
    output logic power_switches_off,
    output logic sink_positive_output,
    output logic sink_boost_intermediate_node,
    output logic sink_negative_output,
    output logic powered_down,
    output logic programming_active,
    output logic [7:0] active_config_byte0,
    output logic [7:0] active_config_byte1,
    output logic [7:0] active_config_byte2
);
    import ocl_pkg::*;

    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    // Reset is asserted at once but released two edges later.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    logic [2:0] in_meta_q;
    logic [2:0] in_sync_q;
    logic enable_input_n_n_s;
    logic pos_dis_s;
    logic neg_dis_s;
    // Only the second stage is read; the first stage may be metastable.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_q <= 3'b000;
            in_sync_q <= 3'b000;
        end else begin
            in_meta_q <= {neg_discharged, pos_discharged, enable_input_n};
            in_sync_q <= in_meta_q;
        end
    end
    assign enable_input_n_n_s = in_sync_q[0];
    assign pos_dis_s = in_sync_q[1];
    assign neg_dis_s = in_sync_q[2];

    // ----------------------------------------------------------------
    // Configuration, stored bytes and command register
    // ----------------------------------------------------------------
    logic [7:0] live_q [3];
    logic [7:0] live_d [3];
    logic [7:0] stored_q [3];
    logic [7:0] stored_d [3];
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic locked;
    logic wr_en;
    logic rd_en;
    logic ack_q;
    logic [7:0] wbyte;
    logic [7:0] new_cmd;

    // Picks the active byte for one index from select bit and lock.
    function automatic logic [7:0] pick_byte(input logic sel, input logic lock,
                                             input logic [7:0] live, input logic [7:0] stored);
        pick_byte = (sel && !lock) ? live : stored;
    endfunction : pick_byte

    assign locked = stored_q[2][CFG2_LOCK];
    // A write lands only at the edge that accepts it, never in the wait cycle.
    // This keeps a held request from committing twice.
    assign wr_en = avs_write && avs_byteenable[0] && ack_q;
    assign rd_en = avs_read;
    assign wbyte = avs_writedata[7:0];
    assign new_cmd = wbyte & CMD_WMASK;

    // Command decode, fault handling and one-time programming.
    always_comb begin
        live_d = live_q;
        stored_d = stored_q;
        cmd_d = cmd_q;
        if (wr_en) begin
            unique case (avs_address)
                OFS_CFG0: live_d[0] = wbyte;
                OFS_CFG1: live_d[1] = wbyte;
                OFS_CFG2: live_d[2] = wbyte;
                OFS_CMD: begin
                    // Fault bit is kept; writing the clear bit wipes it.
                    cmd_d = {new_cmd[CMD_WSM], cmd_q[CMD_CF] & ~new_cmd[CMD_CF],
                             1'b0, new_cmd[4:0]};
                    // Rising write bit burns the selected live bytes once.
                    if (new_cmd[CMD_WSM] && !cmd_q[CMD_WSM]) begin
                        if (locked) begin
                            cmd_d[CMD_CF] = 1'b1;
                        end else begin
                            for (int i = 0; i < 3; i++) begin
                                // Stored bits only go 0 to 1, as fuses do.
                                if (new_cmd[i]) begin
                                    stored_d[i] = stored_q[i] | live_q[i];
                                end
                            end
                            stored_d[2] = stored_d[2] & CFG2_MASK;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // Configuration state registers; stored bytes survive no power cycle here.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                live_q[i] <= CFG_RESET_VAL;
                stored_q[i] <= CFG_RESET_VAL;
            end
            cmd_q <= CMD_RESET_VAL;
        end else begin
            live_q <= live_d;
            stored_q <= stored_d;
            cmd_q <= cmd_d;
        end
    end

    logic [7:0] act [3];
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            act[i] = pick_byte(cmd_q[i], locked, live_q[i], stored_q[i]);
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle on every access
    // ----------------------------------------------------------------
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] rsel_byte;

    // The wait cycle keeps read data from a flop at the accepting edge.
    always_comb begin
        ack_d = (avs_read || avs_write) && !ack_q;
        unique case (avs_address)
            OFS_CFG0: rsel_byte = locked ? stored_q[0] : (cmd_q[0] ? live_q[0] : stored_q[0]);
            OFS_CFG1: rsel_byte = locked ? stored_q[1] : (cmd_q[1] ? live_q[1] : stored_q[1]);
            OFS_CFG2: begin
                rsel_byte = (locked || !cmd_q[2]) ? stored_q[2] : live_q[2];
                rsel_byte[CFG2_LOCK] = locked;
            end
            OFS_CMD: rsel_byte = cmd_q;
            default: rsel_byte = 8'h00;
        endcase
        rdata_d = rd_en ? {24'h00_0000, rsel_byte} : 32'h0000_0000;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end
    // Waitrequest is combinational, so the master sees it in the first cycle of a request.
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;

    // ----------------------------------------------------------------
    // Power-down sequencer
    // ----------------------------------------------------------------
    ocl_pd_e pd_q;
    ocl_pd_e pd_d;
    logic dis_en;
    assign dis_en = act[2][CFG2_DIS];

    // Walks off, discharge and down, or straight to down with discharge off; a high shutdown pin restarts it.
    always_comb begin
        pd_d = pd_q;
        unique case (pd_q)
            PD_RUN: if (!enable_input_n_n_s) pd_d = dis_en ? PD_OFF : PD_DOWN;
            PD_OFF: pd_d = PD_DISCHARGE;
            PD_DISCHARGE: if (pos_dis_s && neg_dis_s) pd_d = PD_DOWN;
            PD_DOWN: if (enable_input_n_n_s) pd_d = PD_RUN;
        endcase
    end

    // Reset starts powered down; the pin must be seen high before the converters run.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_q <= PD_DOWN;
        end else begin
            pd_q <= pd_d;
        end
    end

    logic sink_on;
    assign sink_on = (pd_q == PD_DISCHARGE);
    assign converters_on = (pd_q == PD_RUN) && !cmd_q[CMD_POWER_SWITCHES_OFF];
    assign power_switches_off = cmd_q[CMD_POWER_SWITCHES_OFF];
    assign sink_positive_output = sink_on;
    assign sink_boost_intermediate_node = sink_on;
    assign sink_negative_output = sink_on;
    assign powered_down = (pd_q == PD_DOWN);
    assign programming_active = cmd_q[CMD_WSM] && !locked;
    assign active_config_byte0 = act[0];
    assign active_config_byte1 = act[1];
    assign active_config_byte2 = act[2];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    off_before_sink_a: assert property ($rose(sink_on) |-> $past(pd_q) == PD_OFF && !converters_on)
        else $error("Sinks enabled without converters off first.");
    sink_follows_off_a: assert property (pd_q == PD_OFF |=> sink_on)
        else $error("Sinks not enabled after converters off.");
    sink_hold_a: assert property (sink_on && !(pos_dis_s && neg_dis_s) |=> sink_on)
        else $error("Sinks dropped before outputs discharged.");
    quick_down_a: assert property (pd_q == PD_RUN && !enable_input_n_n_s && !dis_en |=> powered_down)
        else $error("No immediate shutdown with discharge disabled.");
    lock_active_a: assert property (locked |-> act[0] == stored_q[0] && act[2] == stored_q[2])
        else $error("Locked device uses live bytes.");
    lock_fault_a: assert property (locked && wr_en && avs_address == OFS_CMD && wbyte[CMD_WSM]
        && !cmd_q[CMD_WSM] |=> cmd_q[CMD_CF] && stored_q[0] == $past(stored_q[0]))
        else $error("Program while locked did not fault or changed storage.");
    fault_sticky_a: assert property (cmd_q[CMD_CF] && !(wr_en && avs_address == OFS_CMD)
        |=> cmd_q[CMD_CF])
        else $error("Fault flag dropped without a clear.");
    clear_fault_a: assert property (!locked && wr_en && avs_address == OFS_CMD
        && wbyte == 8'h50 |=> !cmd_q[CMD_CF] && power_switches_off)
        else $error("Command 50h did not clear fault and stop switches.");
    lock_read_a: assert property (rd_en && avs_address == OFS_CFG2 && !ack_q
        |=> avs_readdata[CFG2_LOCK] == locked)
        else $error("Lock bit read back wrong.");
    wait_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus access waited more than one cycle.");

    discharge_c: cover property (sink_on ##[1:50] powered_down);
    program_c: cover property (!locked && wr_en && avs_address == OFS_CMD && wbyte == 8'h91);
    locked_fault_c: cover property (locked && cmd_q[CMD_CF]);

    // Programming start, stop and copy, and the locked read-back path.
    prog_start_a: assert property (wr_en && avs_address == OFS_CMD && wbyte[CMD_WSM]
        |=> cmd_q[CMD_WSM])
        else $error("Write bit set did not start programming.");
    prog_stop_a: assert property (wr_en && avs_address == OFS_CMD && !wbyte[CMD_WSM]
        |=> !programming_active)
        else $error("Clearing the write bit did not stop programming.");
    prog_store_a: assert property (!locked && wr_en && avs_address == OFS_CMD
        && wbyte[CMD_WSM] && wbyte[0] && !cmd_q[CMD_WSM]
        |=> (stored_q[0] | $past(live_q[0])) == stored_q[0])
        else $error("Selected live byte 0 not copied into storage.");
    store_read_a: assert property (locked && rd_en && avs_address == OFS_CFG0 && !ack_q
        |=> avs_readdata[7:0] == stored_q[0])
        else $error("Locked read of byte 0 did not return storage.");

    // Covers for the quick shutdown and the locked read-back.
    quick_down_c: cover property (pd_q == PD_RUN && !enable_input_n_n_s && !dis_en ##1 powered_down);
    locked_read_c: cover property (locked && rd_en && avs_address == OFS_CFG0 && ack_q);
endmodule : ocl_ctrl

//--- testbench/ocl_plant.sv
// Behavioural model of the output nodes and their near-ground comparators.
`timescale 1ns/1ps
module ocl_plant #(
    parameter int DELAY = 20
) (
    input wire logic clk_sys,
    input wire logic converters_on,
    input wire logic sink_positive_output,
    input wire logic sink_negative_output,
    output logic pos_discharged,
    output logic neg_discharged
);
    // ----------------------------------------------------------------
    // Discharge timing
    // ----------------------------------------------------------------
    int cnt_q = 0;
    logic pos_q = 1'b0;
    logic neg_q = 1'b0;
    // The negative node is slower, so the controller must wait for both flags.
    assign pos_discharged = pos_q;
    assign neg_discharged = neg_q;
    always @(posedge clk_sys) begin
        if (converters_on) begin
            cnt_q <= 0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (sink_positive_output && sink_negative_output) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q >= DELAY) pos_q <= 1'b1;
            if (cnt_q >= DELAY + 4) neg_q <= 1'b1;
        end
    end
endmodule : ocl_plant

//--- testbench/ocl_ctrl_tb.sv
// Self-checking bench for the stored-configuration and discharge controller.
`timescale 1ns/1ps
module ocl_ctrl_tb;
    import ocl_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, enable_input_n = 1'b1, pos_dis, neg_dis, conv_on, sw_off;
    logic snk_p, snk_c, snk_n, pdown, prog_act;
    logic [7:0] act0, act1, act2;
    int fails = 0;
    int tests_run = 0;
    always #10 clk_sys = ~clk_sys;
    ocl_ctrl i_ocl_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .enable_input_n(enable_input_n),
        .pos_discharged(pos_dis), .neg_discharged(neg_dis), .converters_on(conv_on),
        .power_switches_off(sw_off), .sink_positive_output(snk_p),
        .sink_boost_intermediate_node(snk_c), .sink_negative_output(snk_n),
        .powered_down(pdown), .programming_active(prog_act), .active_config_byte0(act0),
        .active_config_byte1(act1), .active_config_byte2(act2));
    ocl_plant i_ocl_plant (.clk_sys(clk_sys), .converters_on(conv_on),
        .sink_positive_output(snk_p), .sink_negative_output(snk_n),
        .pos_discharged(pos_dis), .neg_discharged(neg_dis));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task timeout(input string msg);
        check(1'b0, 1'b1, msg);
        print_verdict();
    endtask : timeout
    // Holds the request until waitrequest is sampled low, then releases it.
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) timeout("bus answer");
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Let the accepting edge settle so callers see the committed registers.
        #1;
    endtask : bus
    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, {24'h00_0000, exp}, msg);
    endtask : rd
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_select();
        wr(OFS_CMD, 8'h50);
        check(sw_off, 1'b1, "switches off");
        rd(OFS_CMD, 8'h10, "cmd after 50h");
        wr(OFS_CMD, 8'h38);
        rd(OFS_CMD, 8'h10, "reserved bits read 0");
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h00, "unmapped read");
        wr(OFS_CFG0, 8'ha5);
        wr(OFS_CMD, 8'h11);
        check(act0, 8'ha5, "live byte active");
        wr(OFS_CMD, 8'h10);
        check(act0, 8'h00, "stored byte active");
        $display("test select done");
    endtask : t_select
    // The programming supply is taken as present all run, so it outlasts every byte.
    task t_program();
        wr(OFS_CMD, 8'h11);
        wr(OFS_CMD, 8'h91);
        check(prog_act, 1'b1, "programming on");
        wr(OFS_CMD, 8'h11);
        check(prog_act, 1'b0, "programming off");
        rd(OFS_CMD, 8'h11, "no fault");
        wr(OFS_CMD, 8'h10);
        rd(OFS_CFG0, 8'ha5, "stored byte 0");
        check(act0, 8'ha5, "stored active");
        $display("test program done");
    endtask : t_program
    // Drops the shutdown pin and follows the power-down sequence.
    task t_pdown(input logic [7:0] cfg2);
        logic prev;
        int n;
        wr(OFS_CFG2, cfg2);
        wr(OFS_CMD, 8'h04);
        check(conv_on, 1'b1, "running");
        check(act2, cfg2, "live byte 2 active");
        @(posedge clk_sys);
        enable_input_n <= 1'b0;
        prev = 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
            if (snk_p === 1'b1 && !cfg2[2]) check(1'b1, 1'b0, "sink without discharge");
            if (snk_p === 1'b1 && prev !== 1'b0) check(prev, 1'b0, "off before sink");
            if (snk_p === 1'b1) check({snk_p, snk_c, snk_n}, 3'b111, "sinks");
            if (pdown !== 1'b1 && prev === 1'b0 && cfg2[2]) check(snk_p, 1'b1, "sink held");
            // Converter state of this edge, judged against the sinks at the next one.
            prev = conv_on;
        end while (pdown !== 1'b1 && n < 100);
        if (n >= 100) timeout("power down");
        if (!cfg2[2]) check(n < 6, 1'b1, "prompt shutdown");
        else check({pos_dis, neg_dis, snk_p}, 3'b110, "both discharged");
        @(posedge clk_sys);
        enable_input_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check(pdown, 1'b0, "restart");
        $display("test power down %h done", cfg2);
    endtask : t_pdown
    task t_lock();
        wr(OFS_CMD, 8'h50);
        wr(OFS_CFG2, 8'h40);
        wr(OFS_CMD, 8'h54);
        wr(OFS_CMD, 8'hd4);
        wr(OFS_CMD, 8'h54);
        rd(OFS_CFG2, 8'h40, "lock bit");
        wr(OFS_CMD, 8'h50);
        rd(OFS_CFG2, 8'h40, "lock from store");
        wr(OFS_CFG0, 8'h3c);
        wr(OFS_CMD, 8'h11);
        check(act0, 8'ha5, "locked active");
        check(act1, 8'h00, "locked byte 1");
        rd(OFS_CFG0, 8'ha5, "locked read");
        wr(OFS_CMD, 8'h91);
        wr(OFS_CMD, 8'h11);
        rd(OFS_CMD, 8'h51, "fault set");
        rd(OFS_CFG0, 8'ha5, "store kept");
        wr(OFS_CMD, 8'h11);
        rd(OFS_CMD, 8'h51, "fault held");
        wr(OFS_CMD, 8'h50);
        rd(OFS_CMD, 8'h10, "fault cleared");
        wr(OFS_CMD, 8'h00);
        check(sw_off, 1'b0, "switches on");
        $display("test lock done");
    endtask : t_lock
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(OFS_CMD, CMD_RESET_VAL, "cmd reset");
        rd(OFS_CFG2, CFG_RESET_VAL, "cfg reset");
        t_select();
        t_program();
        t_pdown(8'h03);
        t_pdown(8'h07);
        t_lock();
        print_verdict();
    end
endmodule : ocl_ctrl_tb
